//--- uebuf_mcu.sv
/*
  microcontroller model driving the parallel bus pins of uebuf_top.
  assumes ref_clk at 50 MHz and the two-stage pin synchroniser of the block.
*/
`timescale 1ns/1ps
`default_nettype none
module uebuf_mcu (
  // clock
  input wire logic ref_clk,
  // bus pins
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic byte_access,
  output logic [7:0] addr,
  output logic [15:0] data_in
);
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    byte_access = 1'b0;
    addr = 8'h00;
    data_in = 16'h0000;
  end

  // one strobe per access; the bench samples read data while the strobe is held
  task automatic access(input logic is_wr, input logic [7:0] a, input logic b8,
                        input logic [15:0] d);
    @(posedge ref_clk);
    cs_n <= 1'b0;
    addr <= a;
    byte_access <= b8;
    data_in <= d;
    rd_n <= is_wr;
    wr_n <= !is_wr;
    // low 5 clocks: covers 2 sync stages plus the answer edge
    repeat (5) @(posedge ref_clk);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    // a released bus must not look like the last value
    data_in <= ~d;
    repeat (4) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

//--- uebuf_pkg.sv
/*
  types shared by the endpoint buffer access block.
  assumes nothing beyond a systemverilog compiler.
*/
package uebuf_pkg;
  // usb side events, one-cycle pulses from the serial engine
  typedef struct packed {
    logic setup_tok;
    logic out_ack;
    logic in_ack;
    logic status_done;
    logic bus_reset;
  } uebuf_sie_ev_t;

  typedef enum logic [1:0] {HS_NAK, HS_ACK} uebuf_hs_t;

  typedef enum logic {ACC_IDLE, ACC_BUSY} uebuf_acc_t;
endpackage

//--- uebuf_ram.sv
/*
  byte store for all endpoint buffers, addressed by buffer and offset.
  assumes one microcontroller port (two bytes) and one usb engine port.
*/
`timescale 1ns/1ps
`default_nettype none
module uebuf_ram (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // microcontroller port
  input wire logic cpu_we_lo,
  input wire logic cpu_we_hi,
  input wire logic [16:0] cpu_addr,
  input wire logic [15:0] cpu_wdata,
  output logic [15:0] cpu_rdata,
  // usb engine port
  input wire logic sie_we,
  input wire logic [16:0] sie_waddr,
  input wire logic [7:0] sie_wbyte,
  input wire logic [16:0] sie_raddr,
  output logic [7:0] sie_rbyte
);
  logic [7:0] mem [0:131071];
  logic [16:0] cpu_addr_hi;

  assign cpu_addr_hi = cpu_addr + 17'h00001;
  assign cpu_rdata = {mem[cpu_addr_hi], mem[cpu_addr]};

  // the cpu only writes tx buffers; usb engine writes go to whichever buffer sie_waddr names
  always_ff @(posedge ref_clk) begin
    if (cpu_we_lo) begin
      mem[cpu_addr] <= cpu_wdata[7:0];
    end
    if (cpu_we_hi) begin
      mem[cpu_addr_hi] <= cpu_wdata[15:8];
    end
    if (sie_we) begin
      mem[sie_waddr] <= sie_wbyte;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sie_rbyte <= 8'h00;
    end else begin
      sie_rbyte <= mem[sie_raddr];
    end
  end
endmodule
`default_nettype wire

//--- uebuf_regs.svh
/*
  register offsets, field positions, reset values and timing counts for the
  endpoint buffer access block. assumes a 50 MHz ref_clk.
*/
// Contract
// - hardware clears data_stage_go after data packet acknowledge
// - data_stage_go always reads back as zero
// - status bit picks status answer: nak or ack
// - status bit self-clears on status done or setup
// - stall bit stalls indexed endpoint, never isochronous
// - disable/re-enable after stall resets data toggle
// - 16-bit window reaches indexed fifo, upper byte high
// - in window write advances pointer by access width
// - tx auto-validates when byte count reaches length
// - out window read advances pointer by access width
// - rx buffer clears itself once fully read
// - force_buffer_flush empties indexed buffer on demand
// - max-packet-size write loads packet_byte_count with size
// - usb bus reset zeroes packet_byte_count
// - short length written before last packet validates it
// - byte-count validation only for programmed window access
// - out acknowledge loads packet_byte_count with length
// - odd final byte sits in lower window byte
// - endpoint select and direction choose the buffer
// - setup select only with endpoint zero out
`ifndef UEBUF_REGS_SVH
`define UEBUF_REGS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define UEBUF_OFS_PKT_LEN 8'h1c
`define UEBUF_OFS_WINDOW 8'h20
`define UEBUF_OFS_CTRL 8'h28

// ----------------------------------------
// control function bit positions
// ----------------------------------------
`define UEBUF_BIT_STALL 0
`define UEBUF_BIT_STATUS 1
`define UEBUF_BIT_DATA_GO 2
`define UEBUF_BIT_VALIDATE 3
`define UEBUF_BIT_FLUSH 4

// ----------------------------------------
// reset values and geometry
// ----------------------------------------
`define UEBUF_RST_PKT_LEN 16'h0000
`define UEBUF_RST_WINDOW 16'h0000
`define UEBUF_NUM_BUF 33
`define UEBUF_SETUP_BUF 6'h20

// ----------------------------------------
// firmware spacing after an index write
// ----------------------------------------
`define UEBUF_CLK_NS 20
`define UEBUF_IDX_RD_NS 190
`define UEBUF_IDX_WR_NS 100
`define UEBUF_IDX_RD_CYC ((`UEBUF_IDX_RD_NS + `UEBUF_CLK_NS - 1) / `UEBUF_CLK_NS)
`define UEBUF_IDX_WR_CYC ((`UEBUF_IDX_WR_NS + `UEBUF_CLK_NS - 1) / `UEBUF_CLK_NS)

`endif

//--- uebuf_sync.sv
/*
  two flip-flop synchroniser for a group of pin levels.
  assumes the pins hold steady for several ref_clk periods per access.
*/
`timescale 1ns/1ps
`default_nettype none
module uebuf_sync #(parameter int W = 1) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // levels
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_sync
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      pin_sync <= '0;
    end else begin
      meta_ff <= pin_in;
      pin_sync <= meta_ff;
    end
  end
endmodule
`default_nettype wire

//--- uebuf_top.sv
/*
  indexed endpoint buffer access: data window, packet length register and
  control function bits. assumes the index, endpoint type and max packet
  size registers live elsewhere on ref_clk, and a usb serial engine on
  ref_clk that reports token and handshake events as one-cycle pulses.
*/
`timescale 1ns/1ps
`default_nettype none
`include "uebuf_regs.svh"
module uebuf_top import uebuf_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // microcontroller bus pins
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic byte_access,
  input wire logic [7:0] addr,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic data_oe,
  // indexed endpoint from neighbouring registers
  input wire logic [3:0] target_endpoint_select,
  input wire logic ep_dir,
  input wire logic setup_buffer_select,
  input wire logic ep_is_iso,
  input wire logic ep_enable,
  input wire logic mps_wr,
  input wire logic [10:0] mps_fifo_size,
  // usb serial engine
  input wire uebuf_sie_ev_t sie_ev,
  input wire logic [3:0] sie_ep,
  input wire logic sie_dir,
  input wire logic sie_setup,
  input wire logic [15:0] sie_out_len,
  input wire logic sie_rx_we,
  input wire logic [10:0] sie_rx_addr,
  input wire logic [7:0] sie_rx_byte,
  input wire logic [10:0] sie_tx_addr,
  output logic [7:0] sie_tx_byte,
  output logic sie_tx_valid,
  output logic [15:0] sie_tx_len,
  output logic sie_rx_busy,
  output logic sie_stall,
  output logic sie_toggle,
  output logic sie_data_go,
  output uebuf_hs_t sie_status_hs
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // setup buffer is only reachable as endpoint 0 out
  function automatic logic [5:0] buf_id(input logic [3:0] ep, input logic dir,
                                        input logic setup);
    if (setup && ep == 4'h0 && !dir) begin
      buf_id = `UEBUF_SETUP_BUF;
    end else begin
      buf_id = {1'b0, ep, dir};
    end
  endfunction

  function automatic logic [10:0] step(input logic one_byte);
    step = one_byte ? 11'h001 : 11'h002;
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [27:0] pins_s;
  logic cs_n_s, rd_n_s, wr_n_s, byte_s;
  logic [7:0] addr_s;
  logic [15:0] wdata_s;

  uebuf_sync #(.W(28)) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_in({cs_n, rd_n, wr_n, byte_access, addr, data_in}),
    .pin_sync(pins_s)
  );
  assign {cs_n_s, rd_n_s, wr_n_s, byte_s, addr_s, wdata_s} = pins_s;

  // ----------------------------------------
  // access sequencing
  // ----------------------------------------
  uebuf_acc_t state_ff, nxt_state;
  logic rd_cyc_ff;
  logic wr_go, rd_go;

  // one action per strobe: wait for release before taking another
  assign wr_go = state_ff == ACC_IDLE && !cs_n_s && !wr_n_s;
  assign rd_go = state_ff == ACC_IDLE && !cs_n_s && !rd_n_s && wr_n_s;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ACC_IDLE: begin
        if (wr_go || rd_go) begin
          nxt_state = ACC_BUSY;
        end
      end
      ACC_BUSY: begin
        if (cs_n_s || (rd_n_s && wr_n_s)) begin
          nxt_state = ACC_IDLE;
        end
      end
      default: nxt_state = ACC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_ff <= ACC_IDLE;
      rd_cyc_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (rd_go) begin
        rd_cyc_ff <= 1'b1;
      end else if (nxt_state == ACC_IDLE) begin
        rd_cyc_ff <= 1'b0;
      end
    end
  end

  assign data_oe = state_ff == ACC_BUSY && rd_cyc_ff;

  // ----------------------------------------
  // per-buffer state
  // ----------------------------------------
  logic [10:0] ptr_ff [`UEBUF_NUM_BUF];
  logic [15:0] len_ff [`UEBUF_NUM_BUF];
  logic [15:0] cnt_ff [`UEBUF_NUM_BUF];
  logic full_ff [`UEBUF_NUM_BUF];
  logic stall_ff [`UEBUF_NUM_BUF];
  logic toggle_ff [`UEBUF_NUM_BUF];
  logic status_ff, data_go_ff, ep_enable_ff;

  logic [5:0] sel, sid;
  logic [10:0] ptr_nxt, rx_left;
  logic [15:0] rdata;
  logic one_byte, win_wr, win_rd, ctrl_wr, len_wr;
  logic tx_done, rx_done, validate, flush, ctrl_ep;

  assign sel = buf_id(target_endpoint_select, ep_dir, setup_buffer_select);
  assign sid = buf_id(sie_ep, sie_dir, sie_setup);
  assign ctrl_ep = target_endpoint_select == 4'h0;

  // tx writes are refused while the packet waits for its in token
  assign win_wr = wr_go && addr_s == `UEBUF_OFS_WINDOW && ep_dir && !full_ff[sel];
  assign win_rd = rd_go && addr_s == `UEBUF_OFS_WINDOW && !ep_dir && full_ff[sel];
  assign ctrl_wr = wr_go && addr_s == `UEBUF_OFS_CTRL;
  assign len_wr = wr_go && addr_s == `UEBUF_OFS_PKT_LEN;

  // a single remaining byte forces a one-byte step on a 16-bit read
  assign rx_left = len_ff[sel][10:0] - ptr_ff[sel];
  assign one_byte = byte_s || (win_rd && rx_left == 11'h001);
  assign ptr_nxt = ptr_ff[sel] + step(one_byte);

  // validation counts only bytes moved through the window
  assign tx_done = win_wr && cnt_ff[sel] != 16'h0000 &&
                   {5'h00, ptr_nxt} >= cnt_ff[sel];
  assign rx_done = win_rd && {5'h00, ptr_nxt} >= len_ff[sel];
  assign validate = tx_done || (ctrl_wr && ep_dir && wdata_s[`UEBUF_BIT_VALIDATE]);
  assign flush = ctrl_wr && wdata_s[`UEBUF_BIT_FLUSH];

  // ----------------------------------------
  // buffer memory
  // ----------------------------------------
  uebuf_ram u_ram (
    .ref_clk(ref_clk),
    .rst(rst),
    .cpu_we_lo(win_wr),
    .cpu_we_hi(win_wr && !byte_s),
    .cpu_addr({sel, ptr_ff[sel]}),
    .cpu_wdata(wdata_s),
    .cpu_rdata(rdata),
    .sie_we(sie_rx_we),
    .sie_waddr({sid, sie_rx_addr}),
    .sie_wbyte(sie_rx_byte),
    .sie_raddr({sid, sie_tx_addr}),
    .sie_rbyte(sie_tx_byte)
  );

  // ----------------------------------------
  // pointers, fill state and packet length
  // ----------------------------------------
  // usb events are applied last so a hardware set beats a flush
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `UEBUF_NUM_BUF; i++) begin
        ptr_ff[i] <= 11'h000;
        len_ff[i] <= 16'h0000;
        full_ff[i] <= 1'b0;
      end
    end else begin
      if (win_wr || win_rd) begin
        ptr_ff[sel] <= ptr_nxt;
      end
      if (validate) begin
        full_ff[sel] <= 1'b1;
        len_ff[sel] <= {5'h00, tx_done ? ptr_nxt : ptr_ff[sel]};
        ptr_ff[sel] <= 11'h000;
      end
      if (rx_done || flush) begin
        full_ff[sel] <= 1'b0;
        ptr_ff[sel] <= 11'h000;
      end
      if (sie_ev.in_ack) begin
        full_ff[sid] <= 1'b0;
      end
      if (sie_ev.out_ack) begin
        full_ff[sid] <= 1'b1;
        len_ff[sid] <= sie_out_len;
        ptr_ff[sid] <= 11'h000;
      end
      if (sie_ev.bus_reset) begin
        for (int i = 0; i < `UEBUF_NUM_BUF; i++) begin
          full_ff[i] <= 1'b0;
          ptr_ff[i] <= 11'h000;
        end
      end
    end
  end

  // ----------------------------------------
  // packet_byte_count
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `UEBUF_NUM_BUF; i++) begin
        cnt_ff[i] <= `UEBUF_RST_PKT_LEN;
      end
    end else if (sie_ev.bus_reset) begin
      for (int i = 0; i < `UEBUF_NUM_BUF; i++) begin
        cnt_ff[i] <= 16'h0000;
      end
    end else begin
      if (mps_wr) begin
        cnt_ff[sel] <= {5'h00, mps_fifo_size};
      end
      if (len_wr) begin
        cnt_ff[sel] <= wdata_s;
      end
      if (sie_ev.out_ack) begin
        cnt_ff[sid] <= sie_out_len;
      end
    end
  end

  // ----------------------------------------
  // stall and data toggle
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ep_enable_ff <= 1'b0;
      for (int i = 0; i < `UEBUF_NUM_BUF; i++) begin
        stall_ff[i] <= 1'b0;
        toggle_ff[i] <= 1'b0;
      end
    end else begin
      ep_enable_ff <= ep_enable;
      if (ctrl_wr && !ep_is_iso) begin
        stall_ff[sel] <= wdata_s[`UEBUF_BIT_STALL];
      end
      if (sie_ev.in_ack || sie_ev.out_ack) begin
        toggle_ff[sid] <= !toggle_ff[sid];
      end
      // toggle would otherwise resume mid-sequence after a stall
      if (ep_enable && !ep_enable_ff) begin
        toggle_ff[sel] <= 1'b0;
      end
      if (sie_ev.bus_reset) begin
        for (int i = 0; i < `UEBUF_NUM_BUF; i++) begin
          stall_ff[i] <= 1'b0;
          toggle_ff[i] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // control transfer stage bits
  // ----------------------------------------
  logic ctl_sie;

  assign ctl_sie = sie_ep == 4'h0;

  // firmware writes win over a same-cycle hardware clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status_ff <= 1'b0;
      data_go_ff <= 1'b0;
    end else begin
      if (ctl_sie && (sie_ev.out_ack || sie_ev.in_ack)) begin
        data_go_ff <= 1'b0;
      end
      if (sie_ev.status_done || sie_ev.setup_tok || sie_ev.bus_reset) begin
        status_ff <= 1'b0;
      end
      if (ctrl_wr && ctrl_ep && wdata_s[`UEBUF_BIT_DATA_GO]) begin
        data_go_ff <= 1'b1;
      end
      if (ctrl_wr && ctrl_ep) begin
        status_ff <= wdata_s[`UEBUF_BIT_STATUS];
      end
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      data_out <= `UEBUF_RST_WINDOW;
    end else if (rd_go) begin
      case (addr_s)
        `UEBUF_OFS_WINDOW: begin
          if (!win_rd) begin
            data_out <= 16'h0000;
          end else if (one_byte) begin
            data_out <= {8'h00, rdata[7:0]};
          end else begin
            data_out <= rdata;
          end
        end
        `UEBUF_OFS_PKT_LEN: data_out <= cnt_ff[sel];
        // data_stage_go, validate and flush are actions and read zero
        `UEBUF_OFS_CTRL: data_out <= {14'h0000, status_ff, stall_ff[sel]};
        default: data_out <= 16'h0000;
      endcase
    end
  end

  // ----------------------------------------
  // usb engine view
  // ----------------------------------------
  assign sie_tx_valid = full_ff[sid] && sie_dir;
  assign sie_tx_len = len_ff[sid];
  assign sie_rx_busy = full_ff[sid] && !sie_dir;
  assign sie_stall = stall_ff[sid];
  assign sie_toggle = toggle_ff[sid];
  assign sie_data_go = data_go_ff;
  assign sie_status_hs = status_ff ? HS_ACK : HS_NAK;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  localparam int RD_LAT_MIN = 1;
  localparam int RD_LAT_MAX = 2;

  sequence rd_req_s;
    rd_go && addr_s == `UEBUF_OFS_CTRL;
  endsequence

  sequence status_set_s;
    ctrl_wr && ctrl_ep && wdata_s[`UEBUF_BIT_STATUS];
  endsequence

  data_go_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    (ctl_sie && sie_ev.in_ack && !ctrl_wr) |=> !sie_data_go)
    else $error("data_stage_go not cleared after acknowledge");

  data_go_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
    rd_req_s |-> ##[RD_LAT_MIN:RD_LAT_MAX] (data_oe && !data_out[`UEBUF_BIT_DATA_GO]))
    else $error("data_stage_go read back nonzero");

  status_ack_a: assert property (@(posedge ref_clk) disable iff (rst)
    (status_set_s ##1 !(sie_ev.status_done || sie_ev.setup_tok || sie_ev.bus_reset))
    |-> sie_status_hs == HS_ACK)
    else $error("status stage not acknowledged after set");

  status_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    (sie_ev.setup_tok && !ctrl_wr) |=> sie_status_hs == HS_NAK)
    else $error("status bit survived setup token");

  iso_stall_a: assert property (@(posedge ref_clk) disable iff (rst)
    (ctrl_wr && ep_is_iso && !sie_ev.bus_reset) |=> stall_ff[$past(sel)] == $past(stall_ff[sel]))
    else $error("stall changed on isochronous endpoint");

  toggle_reset_a: assert property (@(posedge ref_clk) disable iff (rst)
    (ep_enable && !ep_enable_ff) |=> !toggle_ff[$past(sel)])
    else $error("data toggle not reset on re-enable");

  tx_ptr_step_a: assert property (@(posedge ref_clk) disable iff (rst)
    (win_wr && !byte_s && !tx_done && !sie_ev.bus_reset)
    |=> ptr_ff[$past(sel)] == $past(ptr_ff[sel]) + 11'h002)
    else $error("tx pointer did not advance by two");

  rx_auto_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    (rx_done && !sie_ev.out_ack) |=> !full_ff[$past(sel)] && ptr_ff[$past(sel)] == 11'h000)
    else $error("rx buffer not cleared after last read");

  mps_load_a: assert property (@(posedge ref_clk) disable iff (rst)
    (mps_wr && !len_wr && !sie_ev.out_ack && !sie_ev.bus_reset)
    |=> cnt_ff[$past(sel)] == {5'h00, $past(mps_fifo_size)})
    else $error("packet_byte_count not loaded from fifo size");

  bus_reset_cnt_a: assert property (@(posedge ref_clk) disable iff (rst)
    sie_ev.bus_reset |=> cnt_ff[sel] == 16'h0000)
    else $error("packet_byte_count not zero after bus reset");
endmodule
`default_nettype wire

//--- usb_endpoint_buffer_access_test.sv
/*
  self-checking bench for uebuf_top: window, length and control bits.
  assumes uebuf_mcu as the bus master and a 50 MHz ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module usb_endpoint_buffer_access_test import uebuf_pkg::*;;
  logic ref_clk, rst, cs_n, rd_n, wr_n, byte_access, data_oe, oe_q;
  logic [7:0] addr;
  logic [15:0] data_in, data_out, sie_out_len, sie_tx_len;
  logic [3:0] target_endpoint_select, sie_ep;
  logic ep_dir, ep_is_iso, ep_enable, mps_wr, sie_dir, sie_rx_we, setup_sel;
  logic [10:0] mps_fifo_size, sie_rx_addr, sie_tx_addr;
  logic [7:0] sie_rx_byte, sie_tx_byte;
  logic sie_tx_valid, sie_rx_busy, sie_stall, sie_toggle, sie_data_go;
  uebuf_sie_ev_t sie_ev;
  uebuf_hs_t sie_status_hs;
  int fail_count = 0, total_checks = 0, cycles = 0, i, k;
  logic [15:0] exp_q[$];
  logic [31:0] lfsr = 32'h5e6f;
  logic [7:0] txb[8], rxb[5];

  uebuf_mcu i_mcu (.ref_clk(ref_clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .byte_access(byte_access), .addr(addr), .data_in(data_in));
  uebuf_top i_dut (.ref_clk(ref_clk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .byte_access(byte_access), .addr(addr), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .target_endpoint_select(target_endpoint_select), .ep_dir(ep_dir),
    .setup_buffer_select(setup_sel), .ep_is_iso(ep_is_iso), .ep_enable(ep_enable),
    .mps_wr(mps_wr), .mps_fifo_size(mps_fifo_size), .sie_ev(sie_ev), .sie_ep(sie_ep),
    .sie_dir(sie_dir), .sie_setup(setup_sel), .sie_out_len(sie_out_len), .sie_rx_we(sie_rx_we),
    .sie_rx_addr(sie_rx_addr), .sie_rx_byte(sie_rx_byte), .sie_tx_addr(sie_tx_addr),
    .sie_tx_byte(sie_tx_byte), .sie_tx_valid(sie_tx_valid), .sie_tx_len(sie_tx_len),
    .sie_rx_busy(sie_rx_busy), .sie_stall(sie_stall), .sie_toggle(sie_toggle),
    .sie_data_go(sie_data_go), .sie_status_hs(sie_status_hs));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic rd(input logic [7:0] a, input logic b8, input logic [15:0] e);
    exp_q.push_back(e);
    i_mcu.access(1'b0, a, b8, 16'h0000);
  endtask

  task automatic wr(input logic [7:0] a, input logic b8, input logic [15:0] d);
    i_mcu.access(1'b1, a, b8, d);
  endtask

  task automatic ev(input logic [4:0] e);
    @(posedge ref_clk);
    sie_ev <= e;
    @(posedge ref_clk);
    sie_ev <= 5'h00;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic idx(input logic [3:0] ep, input logic dir);
    @(posedge ref_clk);
    target_endpoint_select <= ep;
    ep_dir <= dir;
    sie_ep <= ep;
    sie_dir <= dir;
    repeat (10) @(posedge ref_clk);
  endtask

  // read results are compared when data_oe rises, oldest note first
  always @(negedge ref_clk) begin
    oe_q <= data_oe;
    if (data_oe === 1'b1 && oe_q !== 1'b1) begin
      check("read data", data_out, exp_q.size() ? exp_q.pop_front() : 16'hdead);
    end
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      $display("ERROR timeout");
      conclude();
    end
  end

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    {target_endpoint_select, ep_dir, ep_is_iso, mps_wr, sie_ep, sie_dir} = 12'h000;
    {mps_fifo_size, sie_rx_addr, sie_tx_addr} = 33'h0;
    {sie_out_len, sie_rx_we, sie_rx_byte} = 25'h0;
    ep_enable = 1'b1;
    setup_sel = 1'b0;
    sie_ev = 5'h00;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    idx(4'h1, 1'b0);
    rd(8'h1c, 1'b0, 16'h0000);
    rd(8'h20, 1'b0, 16'h0000);
    rd(8'h30, 1'b0, 16'h0000);
    // full packet auto-validates at the max packet size
    idx(4'h1, 1'b1);
    @(posedge ref_clk);
    mps_fifo_size <= 11'h008;
    mps_wr <= 1'b1;
    @(posedge ref_clk);
    mps_wr <= 1'b0;
    rd(8'h1c, 1'b0, 16'h0008);
    for (i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      txb[2*i] = lfsr[7:0];
      txb[2*i+1] = lfsr[15:8];
      @(negedge ref_clk);
      check("tx valid early", {15'h0, sie_tx_valid}, 16'h0000);
      wr(8'h20, 1'b0, lfsr[15:0]);
    end
    @(negedge ref_clk);
    check("tx valid", {15'h0, sie_tx_valid}, 16'h0001);
    check("tx len", sie_tx_len, 16'h0008);
    for (i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      sie_tx_addr <= i[10:0];
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      check("tx byte", {8'h00, sie_tx_byte}, {8'h00, txb[i]});
    end
    ev(5'b00100);
    check("tx emptied", {15'h0, sie_tx_valid}, 16'h0000);
    check("toggle flip", {15'h0, sie_toggle}, 16'h0001);
    wr(8'h28, 1'b0, 16'h0001);
    @(negedge ref_clk);
    check("stall", {15'h0, sie_stall}, 16'h0001);
    rd(8'h28, 1'b0, 16'h0001);
    @(posedge ref_clk);
    ep_enable <= 1'b0;
    repeat (3) @(posedge ref_clk);
    ep_enable <= 1'b1;
    repeat (3) @(negedge ref_clk);
    check("toggle reset", {15'h0, sie_toggle}, 16'h0000);
    // short packet by length, 8-bit writes
    wr(8'h1c, 1'b0, 16'h0003);
    for (i = 0; i < 3; i++) begin
      @(negedge ref_clk);
      check("short early", {15'h0, sie_tx_valid}, 16'h0000);
      lfsr = lfsr_next(lfsr);
      wr(8'h20, 1'b1, lfsr[15:0]);
    end
    @(negedge ref_clk);
    check("short valid", {15'h0, sie_tx_valid}, 16'h0001);
    check("short len", sie_tx_len, 16'h0003);
    ev(5'b00100);
    // isochronous endpoint ignores stall; validate bit sends short packet
    idx(4'h2, 1'b1);
    ep_is_iso <= 1'b1;
    wr(8'h28, 1'b0, 16'h0001);
    @(negedge ref_clk);
    check("iso stall", {15'h0, sie_stall}, 16'h0000);
    @(posedge ref_clk);
    ep_is_iso <= 1'b0;
    wr(8'h20, 1'b1, 16'h00a5);
    wr(8'h28, 1'b0, 16'h0008);
    @(negedge ref_clk);
    check("vbit valid", {15'h0, sie_tx_valid}, 16'h0001);
    check("vbit len", sie_tx_len, 16'h0001);
    // odd OUT packet drains and clears itself
    idx(4'h1, 1'b0);
    for (i = 0; i < 5; i++) begin
      lfsr = lfsr_next(lfsr);
      rxb[i] = lfsr[7:0];
      @(posedge ref_clk);
      sie_rx_we <= 1'b1;
      sie_rx_addr <= i[10:0];
      sie_rx_byte <= lfsr[7:0];
    end
    @(posedge ref_clk);
    sie_rx_we <= 1'b0;
    sie_out_len <= 16'h0005;
    ev(5'b01000);
    check("rx full", {15'h0, sie_rx_busy}, 16'h0001);
    rd(8'h1c, 1'b0, 16'h0005);
    rd(8'h20, 1'b0, {rxb[1], rxb[0]});
    rd(8'h20, 1'b0, {rxb[3], rxb[2]});
    rd(8'h20, 1'b0, {8'h00, rxb[4]});
    @(negedge ref_clk);
    check("rx drained", {15'h0, sie_rx_busy}, 16'h0000);
    @(posedge ref_clk);
    sie_out_len <= 16'h0002;
    ev(5'b01000);
    wr(8'h28, 1'b0, 16'h0010);
    @(negedge ref_clk);
    check("rx flushed", {15'h0, sie_rx_busy}, 16'h0000);
    rd(8'h20, 1'b0, 16'h0000);
    // endpoint 0: data stage enable cleared by in and out acknowledge
    for (k = 0; k < 2; k++) begin
      idx(4'h0, k[0] ? 1'b0 : 1'b1);
      wr(8'h28, 1'b0, 16'h0004);
      @(negedge ref_clk);
      check("dsgo set", {15'h0, sie_data_go}, 16'h0001);
      rd(8'h28, 1'b0, 16'h0000);
      sie_out_len <= 16'h0000;
      ev(k[0] ? 5'b01000 : 5'b00100);
      check("dsgo clear", {15'h0, sie_data_go}, 16'h0000);
    end
    // status bit answers ack until status done or a setup token clears it
    for (k = 0; k < 2; k++) begin
      wr(8'h28, 1'b0, 16'h0002);
      @(negedge ref_clk);
      check("status ack", {14'h0, sie_status_hs}, {14'h0, HS_ACK});
      rd(8'h28, 1'b0, 16'h0002);
      ev(k[0] ? 5'b10000 : 5'b00010);
      check("status nak", {14'h0, sie_status_hs}, {14'h0, HS_NAK});
    end
    // setup buffer is a separate buffer, reached only as endpoint 0 out
    @(posedge ref_clk);
    setup_sel <= 1'b1;
    sie_out_len <= 16'h0006;
    ev(5'b01000);
    rd(8'h1c, 1'b0, 16'h0006);
    setup_sel <= 1'b0;
    rd(8'h1c, 1'b0, 16'h0000);
    idx(4'h1, 1'b1);
    ev(5'b00001);
    rd(8'h1c, 1'b0, 16'h0000);
    repeat (4) @(posedge ref_clk);
    check("pending reads", 16'(exp_q.size()), 16'h0000);
    conclude();
  end
endmodule
`default_nettype wire
